//--- logic/vrl_dec_if.sv
`timescale 1ns/10ps
`default_nettype none
interface vrl_dec_if;
  logic [vrl_pkg::DATA_W-1:0] ctl;
  logic [vrl_pkg::TAPS-1:0] tap_sel;
  logic [vrl_pkg::LEVEL_W-1:0] level;
  modport dec (input ctl, output tap_sel, output level);
  modport use_side (output ctl, input tap_sel, input level);
endinterface : vrl_dec_if
`default_nettype wire

//--- logic/vrl_decode.sv
`timescale 1ns/10ps
`default_nettype none
module vrl_decode (
  vrl_dec_if.dec d
);
  logic power;
  logic low_range;
  logic [vrl_pkg::TAP_W-1:0] tap;
  logic [vrl_pkg::LEVEL_W-1:0] tap_ext;

  assign power = d.ctl[vrl_pkg::POWER_BIT];
  assign low_range = d.ctl[vrl_pkg::RANGE_BIT];
  assign tap = d.ctl[vrl_pkg::TAP_LSB +: vrl_pkg::TAP_W];
  assign tap_ext = {3'h0, tap};

  ////////////////////////////////////////////////////////////////////////
  // One ladder tap per code
  genvar i;
  generate
    for (i = 0; i < vrl_pkg::TAPS; i++) begin : g_tap
      assign d.tap_sel[i] = power && (tap == 4'(i));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Level in 96ths of supply
  always_comb begin
    if (!power) begin
      d.level = 7'h00;
    end else if (low_range) begin
      d.level = 7'(tap_ext * vrl_pkg::LOW_MUL);
    end else begin
      d.level = 7'(vrl_pkg::HIGH_BASE + tap_ext * vrl_pkg::HIGH_MUL);
    end
  end
endmodule : vrl_decode
`default_nettype wire

//--- logic/vrl_pkg.sv
`default_nettype none
package vrl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int TAP_W = 4;
  localparam int TAPS = 16;
  localparam int LEVEL_W = 7;
  localparam logic [ADDR_W-1:0] CTL_ADDR = 8'h9f;
  localparam logic [DATA_W-1:0] CTL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CTL_WMASK = 8'hef;
  localparam int POWER_BIT = 7;
  localparam int DRIVE_BIT = 6;
  localparam int RANGE_BIT = 5;
  localparam int UNUSED_BIT = 4;
  localparam int TAP_LSB = 0;
  localparam int LOW_DEN = 24;
  localparam int HIGH_DEN = 32;
  localparam int LEVEL_SCALE = 96;
  localparam logic [LEVEL_W-1:0] LOW_MUL = 7'h04;
  localparam logic [LEVEL_W-1:0] HIGH_MUL = 7'h03;
  localparam logic [LEVEL_W-1:0] HIGH_BASE = 7'h18;
  localparam logic [2:0] CMP_REF_MODE = 3'h2;
  localparam logic [TAPS-1:0] TAP_ONE = 16'h0001;

  typedef struct packed {
    logic [DATA_W-1:0] ctl;
    logic [DATA_W-1:0] rdata;
    logic [TAPS-1:0] tap_sel;
    logic [LEVEL_W-1:0] level;
    logic pin_oe_n;
    logic cmp_ref_sel;
  } vrl_state_s;

  localparam vrl_state_s STATE_RESET = '{
    ctl: CTL_RESET,
    rdata: 8'h00,
    tap_sel: 16'h0000,
    level: 7'h00,
    pin_oe_n: 1'b1,
    cmp_ref_sel: 1'b0
  };
endpackage : vrl_pkg
`default_nettype wire

//--- logic/vrl_top.sv
`timescale 1ns/10ps
`default_nettype none

module vrl_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic [vrl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [vrl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [vrl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic port_direction_bit,
  input wire logic [2:0] comparator_mode_field,
  output logic ladder_power_on,
  output logic ref_pin_drive,
  output logic low_range_select,
  output logic [vrl_pkg::TAP_W-1:0] tap_code,
  output logic [vrl_pkg::TAPS-1:0] ladder_tap_sel,
  output logic [vrl_pkg::LEVEL_W-1:0] ref_level,
  output logic [vrl_pkg::LEVEL_W-1:0] shared_port_pin_out,
  output logic shared_port_pin_oe_n,
  output logic noninverting_input_ref_sel
);
  vrl_pkg::vrl_state_s st_r;
  vrl_pkg::vrl_state_s st_nxt;
  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic [vrl_pkg::DATA_W-1:0] ctl_nxt;

  vrl_dec_if dec_bus ();

  vrl_decode u_decode (
    .d(dec_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  assign hit = (reg_addr == vrl_pkg::CTL_ADDR);
  assign wr_hit = reg_wr && hit;
  assign rd_hit = reg_rd && hit;

  ////////////////////////////////////////////////////////////////////////
  // Control next value
  assign ctl_nxt = wr_hit ? (reg_wdata & vrl_pkg::CTL_WMASK) : st_r.ctl;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.ctl = ctl_nxt;
    st_nxt.rdata = 8'h00;
    if (rd_hit) begin
      st_nxt.rdata = st_r.ctl & vrl_pkg::CTL_WMASK;
    end
    st_nxt.tap_sel = dec_bus.tap_sel;
    st_nxt.level = dec_bus.level;
    st_nxt.pin_oe_n = !(ctl_nxt[vrl_pkg::DRIVE_BIT] && port_direction_bit);
    st_nxt.cmp_ref_sel = (comparator_mode_field == vrl_pkg::CMP_REF_MODE);
  end

  assign dec_bus.ctl = ctl_nxt;

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= vrl_pkg::STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = st_r.rdata;
  assign ladder_power_on = st_r.ctl[vrl_pkg::POWER_BIT];
  assign ref_pin_drive = st_r.ctl[vrl_pkg::DRIVE_BIT];
  assign low_range_select = st_r.ctl[vrl_pkg::RANGE_BIT];
  assign tap_code = st_r.ctl[vrl_pkg::TAP_LSB +: vrl_pkg::TAP_W];
  assign ladder_tap_sel = st_r.tap_sel;
  assign ref_level = st_r.level;
  assign shared_port_pin_out = st_r.level;
  assign shared_port_pin_oe_n = st_r.pin_oe_n;
  assign noninverting_input_ref_sel = st_r.cmp_ref_sel;

  ////////////////////////////////////////////////////////////////////////
  // Reset checks
  reset_power_a: assert property (
    @(posedge clk) srst |=> !ladder_power_on
  ) else $error("power-on bit not cleared by reset");

  reset_drive_a: assert property (
    @(posedge clk) srst |=> !ref_pin_drive && shared_port_pin_oe_n
  ) else $error("pin drive not cleared by reset");

  reset_range_a: assert property (
    @(posedge clk) srst |=> !low_range_select
  ) else $error("range bit not cleared by reset");

  reset_tap_a: assert property (
    @(posedge clk) srst |=> tap_code == 4'h0
  ) else $error("tap code not cleared by reset");

  ////////////////////////////////////////////////////////////////////////
  // Level checks
  low_range_a: assert property (
    @(posedge clk) disable iff (srst)
    ladder_power_on && low_range_select
      |-> ref_level == 7'({3'h0, tap_code} * 7'h04)
  ) else $error("low range level wrong");

  high_range_a: assert property (
    @(posedge clk) disable iff (srst)
    ladder_power_on && !low_range_select
      |-> ref_level == 7'(7'h18 + {3'h0, tap_code} * 7'h03)
  ) else $error("high range level wrong");

  tap_onehot_a: assert property (
    @(posedge clk) disable iff (srst)
    ladder_power_on |-> ladder_tap_sel == (vrl_pkg::TAP_ONE << tap_code)
  ) else $error("tap select not one-hot on code");

  power_off_a: assert property (
    @(posedge clk) disable iff (srst)
    !ladder_power_on |-> ref_level == 7'h00 && ladder_tap_sel == 16'h0000
  ) else $error("ladder active while powered down");

  ////////////////////////////////////////////////////////////////////////
  // Pin and comparator checks
  pin_gate_a: assert property (
    @(posedge clk) disable iff (srst)
    1'b1 |=> shared_port_pin_oe_n == !(ref_pin_drive && $past(port_direction_bit))
  ) else $error("pin drive gating wrong");

  cmp_ref_a: assert property (
    @(posedge clk) disable iff (srst)
    1'b1 |=> noninverting_input_ref_sel == ($past(comparator_mode_field) == 3'h2)
  ) else $error("comparator reference select wrong");

  mode_indep_a: assert property (
    @(posedge clk) disable iff (srst)
    !wr_hit && $changed(comparator_mode_field) |=> $stable(st_r.ctl)
  ) else $error("comparator mode disturbed reference control");

  ////////////////////////////////////////////////////////////////////////
  // Register checks
  bit4_zero_a: assert property (
    @(posedge clk) disable iff (srst)
    !st_r.ctl[vrl_pkg::UNUSED_BIT] && !reg_rdata[vrl_pkg::UNUSED_BIT]
  ) else $error("unimplemented bit not zero");

  hold_value_a: assert property (
    @(posedge clk) disable iff (srst)
    !wr_hit [*2] |=> $stable(st_r.ctl) && $stable(ref_level)
  ) else $error("control changed without a write");

  write_update_a: assert property (
    @(posedge clk) disable iff (srst)
    wr_hit |=> st_r.ctl == ($past(reg_wdata) & vrl_pkg::CTL_WMASK)
      && ladder_tap_sel == (!$past(reg_wdata[vrl_pkg::POWER_BIT]) ? 16'h0000
        : vrl_pkg::TAP_ONE << $past(reg_wdata[vrl_pkg::TAP_LSB +: vrl_pkg::TAP_W]))
  ) else $error("write not applied on completing edge");

  read_data_a: assert property (
    @(posedge clk) disable iff (srst)
    rd_hit |=> reg_rdata == ($past(st_r.ctl) & 8'hef)
  ) else $error("read data wrong");

  read_idle_a: assert property (
    @(posedge clk) disable iff (srst)
    !rd_hit |=> reg_rdata == 8'h00
  ) else $error("read data outside read cycle");

  ////////////////////////////////////////////////////////////////////////
  // Reset of the remaining outputs
  reset_rdata_a: assert property (
    @(posedge clk)
    srst |=> reg_rdata == 8'h00
  ) else $error("read data not cleared by reset");

  reset_ladder_a: assert property (
    @(posedge clk)
    srst |=> ref_level == 7'h00 && ladder_tap_sel == 16'h0000
  ) else $error("ladder outputs not cleared by reset");

  reset_pin_a: assert property (
    @(posedge clk)
    srst |=> shared_port_pin_out == 7'h00 && shared_port_pin_oe_n
  ) else $error("pin outputs not cleared by reset");

  reset_cmp_a: assert property (
    @(posedge clk)
    srst |=> !noninverting_input_ref_sel
  ) else $error("comparator select not cleared by reset");

  ////////////////////////////////////////////////////////////////////////
  // Write field checks
  power_follow_a: assert property (
    @(posedge clk) disable iff (srst)
    wr_hit
      |=> ladder_power_on == $past(reg_wdata[vrl_pkg::POWER_BIT])
  ) else $error("power-on bit not written");

  drive_follow_a: assert property (
    @(posedge clk) disable iff (srst)
    wr_hit
      |=> ref_pin_drive == $past(reg_wdata[vrl_pkg::DRIVE_BIT])
  ) else $error("pin-drive bit not written");

  range_follow_a: assert property (
    @(posedge clk) disable iff (srst)
    wr_hit
      |=> low_range_select == $past(reg_wdata[vrl_pkg::RANGE_BIT])
  ) else $error("range bit not written");

  tap_follow_a: assert property (
    @(posedge clk) disable iff (srst)
    wr_hit
      |=> tap_code == $past(reg_wdata[vrl_pkg::TAP_LSB +: vrl_pkg::TAP_W])
  ) else $error("tap code not written");

  bit4_write_a: assert property (
    @(posedge clk) disable iff (srst)
    wr_hit && reg_wdata[vrl_pkg::UNUSED_BIT]
      |=> !st_r.ctl[vrl_pkg::UNUSED_BIT]
  ) else $error("unimplemented bit took a write");

  ////////////////////////////////////////////////////////////////////////
  // Bus side checks
  unmapped_wr_a: assert property (
    @(posedge clk) disable iff (srst)
    reg_wr && !hit
      |=> $stable(st_r.ctl)
  ) else $error("unmapped write changed control");

  unmapped_rd_a: assert property (
    @(posedge clk) disable iff (srst)
    reg_rd && !hit
      |=> reg_rdata == 8'h00
  ) else $error("unmapped read returned data");

  read_keeps_a: assert property (
    @(posedge clk) disable iff (srst)
    rd_hit
      |=> $stable(st_r.ctl) && $stable(ref_level)
  ) else $error("read disturbed control");

  read_match_a: assert property (
    @(posedge clk) disable iff (srst)
    rd_hit
      |=> reg_rdata == {ladder_power_on, ref_pin_drive, low_range_select, 1'b0, tap_code}
  ) else $error("read data differs from control outputs");

  write_quiet_a: assert property (
    @(posedge clk) disable iff (srst)
    wr_hit
      |=> reg_rdata == 8'h00
  ) else $error("read data during write");

  ////////////////////////////////////////////////////////////////////////
  // Level and pin bounds
  pin_mirror_a: assert property (
    @(posedge clk) disable iff (srst)
    1'b1
      |-> shared_port_pin_out == ref_level
  ) else $error("pin level differs from reference");

  pin_needs_drive_a: assert property (
    @(posedge clk) disable iff (srst)
    !shared_port_pin_oe_n
      |-> ref_pin_drive
  ) else $error("pin driven without drive bit");

  dir_output_a: assert property (
    @(posedge clk) disable iff (srst)
    !port_direction_bit
      |=> shared_port_pin_oe_n
  ) else $error("pin driven while direction is output");

  tap_single_a: assert property (
    @(posedge clk) disable iff (srst)
    1'b1
      |-> $onehot0(ladder_tap_sel)
  ) else $error("more than one tap selected");

  low_max_a: assert property (
    @(posedge clk) disable iff (srst)
    ladder_power_on && low_range_select
      |-> ref_level <= 7'h3c
  ) else $error("low range level above top tap");

  low_zero_a: assert property (
    @(posedge clk) disable iff (srst)
    ladder_power_on && low_range_select && tap_code == 4'h0
      |-> ref_level == 7'h00
  ) else $error("low range bottom tap not zero");

  high_bounds_a: assert property (
    @(posedge clk) disable iff (srst)
    ladder_power_on && !low_range_select
      |-> ref_level >= 7'h18 && ref_level <= 7'h45
  ) else $error("high range level out of span");

  level_power_a: assert property (
    @(posedge clk) disable iff (srst)
    ref_level != 7'h00
      |-> ladder_power_on
  ) else $error("level present while powered down");

  mode_level_a: assert property (
    @(posedge clk) disable iff (srst)
    !wr_hit && $changed(comparator_mode_field)
      |=> $stable(ref_level) && $stable(ladder_tap_sel)
  ) else $error("comparator mode disturbed ladder");

  hold_taps_a: assert property (
    @(posedge clk) disable iff (srst)
    !wr_hit [*2]
      |=> $stable(ladder_tap_sel) && $stable(tap_code)
  ) else $error("tap select changed without a write");

  ////////////////////////////////////////////////////////////////////////
  // Per tap select checks
  for (genvar k = 0; k < vrl_pkg::TAPS; k++) begin : g_tap_chk
    tap_bit_a: assert property (
      @(posedge clk) disable iff (srst)
      ladder_tap_sel[k] |-> ladder_power_on && tap_code == 4'(k)
    ) else $error("tap select bit without its code");
  end
endmodule : vrl_top
`default_nettype wire

//--- testbench/vrl_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module vrl_top_bench;
  typedef struct packed {
    logic [7:0] wd;
    logic dir;
    logic [7:0] rd;
    logic [6:0] lvl;
    logic [15:0] sel;
    logic oe_n;
  } vrl_row_s;
  localparam vrl_row_s ROWS [7] = '{
    '{8'ha6, 1'b1, 8'ha6, 7'h18, 16'h0040, 1'b1},
    '{8'hff, 1'b1, 8'hef, 7'h3c, 16'h8000, 1'b0},
    '{8'hc0, 1'b0, 8'hc0, 7'h18, 16'h0001, 1'b1},
    '{8'hcf, 1'b1, 8'hcf, 7'h45, 16'h8000, 1'b0},
    '{8'h4f, 1'b1, 8'h4f, 7'h00, 16'h0000, 1'b0},
    '{8'h10, 1'b1, 8'h00, 7'h00, 16'h0000, 1'b1},
    '{8'ha0, 1'b1, 8'ha0, 7'h00, 16'h0001, 1'b1}};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic port_direction_bit = 1'b0;
  logic [2:0] comparator_mode_field = 3'h0;
  logic [7:0] reg_rdata;
  logic [7:0] ctl_seen;
  logic ladder_power_on, ref_pin_drive, low_range_select;
  logic shared_port_pin_oe_n, noninverting_input_ref_sel;
  logic [3:0] tap_code;
  logic [15:0] ladder_tap_sel;
  logic [6:0] ref_level, shared_port_pin_out;
  int bad_count = 0;
  int tests_run = 0;
  assign ctl_seen = {ladder_power_on, ref_pin_drive, low_range_select, 1'b0, tap_code};
  vrl_top dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port_direction_bit, .comparator_mode_field, .ladder_power_on, .ref_pin_drive,
    .low_range_select, .tap_code, .ladder_tap_sel, .ref_level, .shared_port_pin_out,
    .shared_port_pin_oe_n, .noninverting_input_ref_sel);
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
  endtask : rd
  task automatic outs(input logic [6:0] l, input logic [15:0] s, input logic o);
    chk("ref_level", 16'(ref_level), 16'(l));
    chk("pin_out", 16'(shared_port_pin_out), 16'(l));
    chk("tap_sel", ladder_tap_sel, s);
    chk("pin_oe_n", 16'(shared_port_pin_oe_n), 16'(o));
  endtask : outs
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1;
    outs(7'h00, 16'h0000, 1'b1);
    chk("ctl", 16'(ctl_seen), 16'h0000);
    foreach (ROWS[i]) begin
      @(posedge clk);
      port_direction_bit <= ROWS[i].dir;
      wr(8'h9f, ROWS[i].wd);
      outs(ROWS[i].lvl, ROWS[i].sel, ROWS[i].oe_n);
      chk("ctl", 16'(ctl_seen), 16'(ROWS[i].rd));
      rd(8'h9f);
      chk("rdata", 16'(reg_rdata), 16'(ROWS[i].rd));
    end
    // Every tap in both ranges
    for (int r = 0; r < 2; r++) begin
      for (int t = 0; t < 16; t++) begin
        wr(8'h9f, {2'b10, r[0], 1'b0, t[3:0]});
        @(posedge clk);
        #1;
        chk("level", 16'(ref_level), 16'(r ? 4 * t : 24 + 3 * t));
        chk("tap_sel", ladder_tap_sel, 16'h0001 << t);
      end
    end
    // Comparator mode sweep
    wr(8'h9f, 8'hb5);
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      comparator_mode_field <= 3'(m);
      repeat (2) @(posedge clk);
      #1;
      chk("ref_sel", 16'(noninverting_input_ref_sel), 16'(m == 2));
      chk("ctl", 16'(ctl_seen), 16'h00a5);
      chk("level", 16'(ref_level), 16'h0014);
    end
    @(posedge clk);
    comparator_mode_field <= 3'h0;
    // Unmapped address and read data lifetime
    wr(8'h9e, 8'h00);
    rd(8'h9f);
    chk("rdata", 16'(reg_rdata), 16'h00a5);
    @(posedge clk);
    #1;
    chk("rdata idle", 16'(reg_rdata), 16'h0000);
    rd(8'h9e);
    chk("rdata unmapped", 16'(reg_rdata), 16'h0000);
    // Reference off before sleep
    wr(8'h9f, 8'h00);
    outs(7'h00, 16'h0000, 1'b1);
    chk("ctl", 16'(ctl_seen), 16'h0000);
    // Reset in mid-run
    wr(8'h9f, 8'hff);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    outs(7'h00, 16'h0000, 1'b1);
    chk("ctl", 16'(ctl_seen), 16'h0000);
    close_out();
  end
endmodule : vrl_top_bench
`default_nettype wire
